// File: src/espt_dev.sv
//Function
// R1: read-only shifter empty flag tracks shift register
// R2: shifter empty flag never raises interrupt
// R3: shift register not reachable by software
// R4: ninth bit enable sends nine bits, MSB last
// R5: software writes ninth bit before low byte
// R6: all nine bits move into shifter together
// R7: set ninth bit marks address, clear data
// R8: software sets baud, clears sync, sets enable
// R9: polarity select inverts async transmit line
// R10: transmit enable sets buffer flag immediately
// R11: flag with all enables raises interrupt
// R12: holding buffer write starts transmission
// R13: slave transmit needs sync, external clock, enable
// R14: slave transmit shifts like master transmit
// R15: sleep: second word stays, flag stays clear
// R16: sleep: second word loads after first, flag sets
// R17: flag with gates wakes device from sleep
// R18: software slave set-up order before low byte
// R19: empty shifter takes buffered character, sets flag
module espt_dev import espt_pkg::*; (
   input wire logic sys_clk, // system clock
   input wire logic rst_n, // async reset, active low
   input wire logic [4:0] addr, // register byte address
   input wire logic [7:0] wdata, // write data
   input wire logic wr, // write strobe
   input wire logic rd, // read strobe
   output logic [7:0] rdata, // read data, cycle after rd
   input wire logic sleep_mode, // device is asleep
   output logic irq, // interrupt request level
   output logic wake, // wake-from-sleep level
   espt_if.dev lnk // serial line
);
   function automatic logic hit(input logic [4:0] a, input logic [4:0] ofs);
      hit = (a == ofs);
   endfunction

   // ---------------------------------------------------------------
   // control registers
   // ---------------------------------------------------------------
   logic [7:0] txc_q, rxc_q, intc_q;
   logic [15:0] brg_q;
   logic [ESPT_EV_W-1:0] ev_st_q, ev_mk_q, ev_set;
   logic d9, hs, wide, sync, transmit_enable, nine_en, clock_source_master, pol, single_receive_enable, continuous_receive_enable, serial_port_enable, txie, pgate, global_irq_enable;
   assign d9 = txc_q[ESPT_TX_D9_BIT];
   assign hs = txc_q[ESPT_TX_HS_BIT];
   assign wide = txc_q[ESPT_TX_WIDE_BIT];
   assign sync = txc_q[ESPT_TX_SYNC_BIT];
   assign transmit_enable = txc_q[ESPT_TX_EN_BIT];
   assign nine_en = txc_q[ESPT_TX_NINE_BIT];
   assign clock_source_master = txc_q[ESPT_TX_CLOCK_SOURCE_MASTER_BIT];
   assign pol = rxc_q[ESPT_RX_POL_BIT];
   assign continuous_receive_enable = rxc_q[ESPT_RX_CONTINUOUS_RECEIVE_ENABLE_BIT];
   assign single_receive_enable = rxc_q[ESPT_RX_SINGLE_RECEIVE_ENABLE_BIT];
   assign serial_port_enable = rxc_q[ESPT_RX_SERIAL_PORT_ENABLE_BIT];
   assign txie = intc_q[ESPT_IC_TXIE_BIT];
   assign pgate = intc_q[ESPT_IC_PGATE_BIT];
   assign global_irq_enable = intc_q[ESPT_IC_GIE_BIT];

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         txc_q <= ESPT_CTL_RST;
         rxc_q <= ESPT_CTL_RST;
         intc_q <= ESPT_CTL_RST;
         brg_q <= ESPT_BAUD_RST;
      end else if (wr) begin
         if (hit(addr, ESPT_TXCTL_OFS)) txc_q <= wdata;
         if (hit(addr, ESPT_RXCTL_OFS)) rxc_q <= wdata;
         if (hit(addr, ESPT_INTC_OFS)) intc_q <= wdata;
         if (hit(addr, ESPT_BAUDL_OFS)) brg_q[7:0] <= wdata;
         if (hit(addr, ESPT_BAUDH_OFS)) brg_q[15:8] <= wdata;
      end
   end

   // ---------------------------------------------------------------
   // mode decode
   // ---------------------------------------------------------------
   logic async_mode, slave_mode, run;
   assign async_mode = serial_port_enable && !sync && transmit_enable;
   assign slave_mode = serial_port_enable && sync && !clock_source_master && !single_receive_enable && !continuous_receive_enable && transmit_enable; // R13
   assign run = async_mode || slave_mode;

   // ---------------------------------------------------------------
   // holding buffer
   // ---------------------------------------------------------------
   logic buf_full_q, buf_d9_q, sh_empty_q, load, hold_wr, flag, flag_q;
   logic [7:0] buf_q;
   assign hold_wr = wr && hit(addr, ESPT_HOLD_OFS) && transmit_enable; // R12
   assign load = run && sh_empty_q && buf_full_q; // R19

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         buf_full_q <= 1'b0;
         buf_q <= 8'h00;
         buf_d9_q <= 1'b0;
      end else if (!transmit_enable) begin
         buf_full_q <= 1'b0;
      end else if (hold_wr && (!buf_full_q || load)) begin
         buf_full_q <= 1'b1;
         buf_q <= wdata;
         buf_d9_q <= d9; // R5
      end else if (load) begin
         buf_full_q <= 1'b0; // R16
      end
   end

   assign flag = transmit_enable && !buf_full_q; // R10 R15

   // ---------------------------------------------------------------
   // baud timing
   // ---------------------------------------------------------------
   logic [15:0] div;
   logic [ESPT_BITCYC_W-1:0] bit_cyc, bcnt_q;
   logic tick_a;
   assign div = wide ? brg_q : {8'h00, brg_q[7:0]};
   assign bit_cyc = ({4'h0, div} + 20'h00001) << (hs ? ESPT_FAST_SHIFT : ESPT_SLOW_SHIFT);
   // async bit clock stops while asleep
   assign tick_a = async_mode && !sh_empty_q && !sleep_mode && (bcnt_q == '0);

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         bcnt_q <= '0;
      end else if (load || tick_a) begin
         bcnt_q <= bit_cyc - 1'b1;
      end else if (!sh_empty_q && !sleep_mode && bcnt_q != '0) begin
         bcnt_q <= bcnt_q - 1'b1;
      end
   end

   // ---------------------------------------------------------------
   // slave clock synchroniser and edge
   // ---------------------------------------------------------------
   logic sck_m_q, sck_s_q, sck_e_q, tick_s;
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         sck_m_q <= 1'b0;
         sck_s_q <= 1'b0;
         sck_e_q <= 1'b0;
      end else begin
         sck_m_q <= lnk.sck;
         sck_s_q <= sck_m_q;
         sck_e_q <= sck_s_q;
      end
   end
   // shift on each rising edge of the polarity-corrected clock
   assign tick_s = slave_mode && !sh_empty_q && !(sck_e_q ^ pol) && (sck_s_q ^ pol); // R14 R16

   // ---------------------------------------------------------------
   // transmit shift register, internal only
   // ---------------------------------------------------------------
   logic [10:0] sh_q; // R3
   logic [3:0] left_q;
   logic adv;
   assign adv = tick_a || tick_s;

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         sh_q <= 11'h7ff;
         left_q <= 4'h0;
         sh_empty_q <= 1'b1;
      end else if (!run) begin
         sh_empty_q <= 1'b1;
         left_q <= 4'h0;
         sh_q <= 11'h7ff;
      end else if (load) begin
         sh_empty_q <= 1'b0; // R1
         if (async_mode) begin
            sh_q <= {1'b1, nine_en ? buf_d9_q : 1'b1, buf_q, 1'b0}; // R4 R6 R7
            left_q <= nine_en ? 4'd11 : 4'd10;
         end else begin
            sh_q <= {2'b11, buf_d9_q, buf_q}; // R4 R6
            left_q <= nine_en ? 4'd9 : 4'd8;
         end
      end else if (adv) begin
         sh_q <= {1'b1, sh_q[10:1]};
         left_q <= left_q - 4'h1;
         if (left_q == 4'h1) sh_empty_q <= 1'b1; // R1
      end
   end

   // ---------------------------------------------------------------
   // line output
   // ---------------------------------------------------------------
   logic line_q, cur;
   assign cur = sh_empty_q ? 1'b1 : sh_q[0];
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         line_q <= 1'b1;
      end else begin
         line_q <= async_mode ? (cur ^ pol) : cur; // R9
      end
   end
   assign lnk.tx_line = line_q;

   // ---------------------------------------------------------------
   // events and interrupt
   // ---------------------------------------------------------------
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         flag_q <= 1'b0;
      end else begin
         flag_q <= flag;
      end
   end
   assign ev_set[ESPT_EV_BUFEMPTY_BIT] = flag && !flag_q;
   assign ev_set[ESPT_EV_OVERRUN_BIT] = hold_wr && buf_full_q && !load;

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         ev_st_q <= ESPT_EV_RST;
      end else if (wr && hit(addr, ESPT_EVST_OFS)) begin
         ev_st_q <= (ev_st_q & ~wdata[ESPT_EV_W-1:0]) | ev_set;
      end else begin
         ev_st_q <= ev_st_q | ev_set;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         ev_mk_q <= ESPT_EV_RST;
      end else if (wr && hit(addr, ESPT_EVMSK_OFS)) begin
         ev_mk_q <= wdata[ESPT_EV_W-1:0];
      end
   end

   // shifter empty takes no part in either term
   logic src;
   assign src = (flag && txie) || (|(ev_st_q & ev_mk_q)); // R2
   assign wake = pgate && src; // R17
   assign irq = global_irq_enable && pgate && src; // R11

   // ---------------------------------------------------------------
   // read port
   // ---------------------------------------------------------------
   logic [7:0] txc_rd, intc_rd;
   always_comb begin
      txc_rd = txc_q;
      txc_rd[ESPT_TX_EMPTY_BIT] = sh_empty_q; // R1
      intc_rd = intc_q;
      intc_rd[ESPT_IC_FLAG_BIT] = flag;
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         rdata <= 8'h00;
      end else if (rd) begin
         case (addr)
            ESPT_TXCTL_OFS: rdata <= txc_rd;
            ESPT_RXCTL_OFS: rdata <= rxc_q;
            ESPT_INTC_OFS: rdata <= intc_rd;
            ESPT_BAUDL_OFS: rdata <= brg_q[7:0];
            ESPT_BAUDH_OFS: rdata <= brg_q[15:8];
            ESPT_EVST_OFS: rdata <= {6'h00, ev_st_q};
            ESPT_EVMSK_OFS: rdata <= {6'h00, ev_mk_q};
            default: rdata <= 8'h00;
         endcase
      end else begin
         rdata <= 8'h00;
      end
   end
endmodule

// File: src/espt_far.sv
module espt_far import espt_pkg::*; #(
   parameter int HALF_CYC = ESPT_HALF_CYC
) (
   input wire logic sys_clk, // system clock
   input wire logic rst_n, // async reset, active low
   input wire logic sync_sel, // 1 = clock words out as sync master
   input wire logic pol, // line polarity (async) / clock polarity (sync)
   input wire logic nine, // 9-bit characters
   input wire logic [ESPT_BITCYC_W-1:0] bit_cycles, // async bit time in sys_clk cycles
   input wire logic clk_start, // pulse: clock one word in sync mode
   output logic [8:0] rx_data, // received character
   output logic rx_valid, // one-cycle pulse with rx_data
   output logic rx_ferr, // stop bit missing, valid with rx_valid
   output logic busy, // frame in progress
   espt_if.far lnk // link to the transmitter
);
   // refuse a half period the sampling point cannot fit into
   if (HALF_CYC < 2) begin : g_half_cyc_check
      $error("HALF_CYC must be at least 2");
   end

   // ---------------------------------------------------------------
   // line synchroniser
   // ---------------------------------------------------------------
   logic ln_m_q, ln_s_q, lvl;
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         ln_m_q <= 1'b1;
         ln_s_q <= 1'b1;
      end else begin
         ln_m_q <= lnk.tx_line;
         ln_s_q <= ln_m_q;
      end
   end
   assign lvl = sync_sel ? ln_s_q : (ln_s_q ^ pol); // R9

   // ---------------------------------------------------------------
   // receiver and sync clock generator
   // ---------------------------------------------------------------
   espt_far_state_t st_q;
   logic [ESPT_BITCYC_W-1:0] cnt_q;
   logic [3:0] n_q, nbits;
   logic [8:0] sh_q;
   logic eff_q;
   logic [8:0] word;
   assign nbits = nine ? 4'd9 : 4'd8;
   assign word = nine ? {lvl, sh_q[8:1]} : {1'b0, lvl, sh_q[8:2]};

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         st_q <= ESPT_FAR_IDLE;
         cnt_q <= '0;
         n_q <= 4'h0;
         sh_q <= 9'h000;
         eff_q <= 1'b0;
         rx_data <= 9'h000;
         rx_valid <= 1'b0;
         rx_ferr <= 1'b0;
      end else begin
         rx_valid <= 1'b0;
         case (st_q)
            ESPT_FAR_IDLE: begin
               n_q <= 4'h0;
               eff_q <= 1'b0;
               if (sync_sel && clk_start) begin
                  st_q <= ESPT_FAR_SCLK;
                  cnt_q <= ESPT_BITCYC_W'(HALF_CYC - 1);
               end else if (!sync_sel && !lvl) begin
                  st_q <= ESPT_FAR_START;
                  cnt_q <= bit_cycles >> 1;
               end
            end
            ESPT_FAR_START: begin
               if (cnt_q == '0) begin
                  st_q <= lvl ? ESPT_FAR_IDLE : ESPT_FAR_BITS;
                  cnt_q <= bit_cycles - 1'b1;
               end else begin
                  cnt_q <= cnt_q - 1'b1;
               end
            end
            ESPT_FAR_BITS: begin
               if (cnt_q == '0) begin
                  cnt_q <= bit_cycles - 1'b1;
                  sh_q <= {lvl, sh_q[8:1]};
                  n_q <= n_q + 4'h1;
                  if (n_q == nbits - 4'h1) begin
                     st_q <= ESPT_FAR_STOP;
                     rx_data <= word;
                  end
               end else begin
                  cnt_q <= cnt_q - 1'b1;
               end
            end
            ESPT_FAR_STOP: begin
               if (cnt_q == '0) begin
                  st_q <= ESPT_FAR_IDLE;
                  rx_valid <= 1'b1;
                  rx_ferr <= !lvl;
               end else begin
                  cnt_q <= cnt_q - 1'b1;
               end
            end
            ESPT_FAR_SCLK: begin
               if (cnt_q != '0) begin
                  cnt_q <= cnt_q - 1'b1;
               end else begin
                  cnt_q <= ESPT_BITCYC_W'(HALF_CYC - 1);
                  eff_q <= !eff_q;
                  if (!eff_q) begin
                     // sample just before the rising edge moves the slave on
                     sh_q <= {lvl, sh_q[8:1]};
                     if (n_q == nbits - 4'h1) begin
                        rx_data <= word;
                     end
                  end else begin
                     n_q <= n_q + 4'h1;
                     if (n_q == nbits - 4'h1) begin
                        st_q <= ESPT_FAR_IDLE;
                        rx_valid <= 1'b1;
                        rx_ferr <= 1'b0;
                     end
                  end
               end
            end
            default: st_q <= ESPT_FAR_IDLE;
         endcase
      end
   end

   assign lnk.sck = eff_q ^ pol;
   assign busy = (st_q != ESPT_FAR_IDLE);
endmodule

// File: src/espt_if.sv
interface espt_if;
   logic tx_line;
   logic sck;
   modport dev (output tx_line, input sck);
   modport far (input tx_line, output sck);
endinterface

// File: src/espt_pkg.sv
package espt_pkg;
   // ---------------------------------------------------------------
   // register offsets (byte addresses)
   // ---------------------------------------------------------------
   localparam logic [4:0] ESPT_TXCTL_OFS = 5'h00;
   localparam logic [4:0] ESPT_RXCTL_OFS = 5'h04;
   localparam logic [4:0] ESPT_HOLD_OFS = 5'h08;
   localparam logic [4:0] ESPT_INTC_OFS = 5'h0c;
   localparam logic [4:0] ESPT_BAUDL_OFS = 5'h10;
   localparam logic [4:0] ESPT_BAUDH_OFS = 5'h14;
   localparam logic [4:0] ESPT_EVST_OFS = 5'h18;
   localparam logic [4:0] ESPT_EVMSK_OFS = 5'h1c;
   // ---------------------------------------------------------------
   // transmit_status_control fields
   // ---------------------------------------------------------------
   localparam int ESPT_TX_D9_BIT = 0;
   localparam int ESPT_TX_EMPTY_BIT = 1;
   localparam int ESPT_TX_HS_BIT = 2;
   localparam int ESPT_TX_WIDE_BIT = 3;
   localparam int ESPT_TX_SYNC_BIT = 4;
   localparam int ESPT_TX_EN_BIT = 5;
   localparam int ESPT_TX_NINE_BIT = 6;
   localparam int ESPT_TX_CLOCK_SOURCE_MASTER_BIT = 7;
   // ---------------------------------------------------------------
   // receive_status_control fields
   // ---------------------------------------------------------------
   localparam int ESPT_RX_POL_BIT = 0;
   localparam int ESPT_RX_CONTINUOUS_RECEIVE_ENABLE_BIT = 4;
   localparam int ESPT_RX_SINGLE_RECEIVE_ENABLE_BIT = 5;
   localparam int ESPT_RX_SERIAL_PORT_ENABLE_BIT = 7;
   // ---------------------------------------------------------------
   // interrupt_control fields
   // ---------------------------------------------------------------
   localparam int ESPT_IC_TXIE_BIT = 0;
   localparam int ESPT_IC_PGATE_BIT = 1;
   localparam int ESPT_IC_GIE_BIT = 2;
   localparam int ESPT_IC_FLAG_BIT = 3;
   // ---------------------------------------------------------------
   // event status / mask fields
   // ---------------------------------------------------------------
   localparam int ESPT_EV_W = 2;
   localparam int ESPT_EV_BUFEMPTY_BIT = 0;
   localparam int ESPT_EV_OVERRUN_BIT = 1;
   // ---------------------------------------------------------------
   // reset values and timing
   // ---------------------------------------------------------------
   localparam logic [7:0] ESPT_CTL_RST = 8'h00;
   localparam logic [15:0] ESPT_BAUD_RST = 16'h0000;
   localparam logic [ESPT_EV_W-1:0] ESPT_EV_RST = 2'h0;
   localparam int ESPT_SLOW_SHIFT = 4;
   localparam int ESPT_FAST_SHIFT = 2;
   localparam int ESPT_BITCYC_W = 20;
   localparam int ESPT_HALF_CYC = 4;
   typedef enum logic [2:0] {ESPT_FAR_IDLE, ESPT_FAR_START, ESPT_FAR_BITS, ESPT_FAR_STOP,
                             ESPT_FAR_SCLK} espt_far_state_t;
endpackage

// File: test/espt_bench.sv
module espt_bench;
   timeunit 1ns;
   timeprecision 1ps;
   import espt_pkg::*;
   logic sys_clk, rst_n, wr, rd, sleep_mode, irq, wake;
   logic sync_sel, pol, nine, clk_start, rx_valid, rx_ferr, busy;
   logic [4:0] addr;
   logic [7:0] wdata, rdata;
   logic [19:0] bit_cycles;
   logic [8:0] rx_data;
   int failures, comparisons;
   espt_if lnk();
   espt_dev u_espt_dev (.sys_clk(sys_clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
      .rdata(rdata), .sleep_mode(sleep_mode), .irq(irq), .wake(wake), .lnk(lnk.dev));
   espt_far #(.HALF_CYC(4)) u_espt_far (.sys_clk(sys_clk), .rst_n(rst_n), .sync_sel(sync_sel), .pol(pol),
      .nine(nine), .bit_cycles(bit_cycles), .clk_start(clk_start), .rx_data(rx_data), .rx_valid(rx_valid),
      .rx_ferr(rx_ferr), .busy(busy), .lnk(lnk.far));
   espt_checker u_espt_checker (.sys_clk(sys_clk), .rst_n(rst_n), .tx_line(lnk.tx_line), .sck(lnk.sck),
      .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .irq(irq), .wake(wake));
   initial begin
      sys_clk = 1'b0;
      forever #20 sys_clk = ~sys_clk;
   end
   // ---------------------------------------------------------------
   // shared tasks
   // ---------------------------------------------------------------
   task test_done;
      $display("counts: %0d comparisons, %0d failures", comparisons, failures);
      if (failures == 0 && comparisons > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   task chk(input logic [8:0] got, input logic [8:0] exp);
      comparisons++;
      if (got !== exp) begin
         failures++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task cyc(input int n);
      repeat (n) @(posedge sys_clk);
   endtask
   task wr_reg(input logic [4:0] a, input logic [7:0] d);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge sys_clk);
      wr <= 1'b0;
      @(posedge sys_clk);
   endtask
   task rdchk(input logic [4:0] a, input logic [7:0] m, input logic [7:0] e);
      addr <= a;
      rd <= 1'b1;
      @(posedge sys_clk);
      rd <= 1'b0;
      #1;
      chk({1'b0, rdata & m}, {1'b0, e});
      @(posedge sys_clk);
   endtask
   task lvl(input logic i, input logic w);
      #1;
      chk({7'h00, irq, wake}, {7'h00, i, w});
      @(posedge sys_clk);
   endtask
   task rx_exp(input logic [8:0] e);
      int i;
      // step off the edge so a pulse from the previous word is already gone
      #1;
      for (i = 0; i < 900 && rx_valid !== 1'b1; i++) begin
         @(posedge sys_clk);
         #1;
      end
      chk(rx_data, e);
      chk({6'h00, busy, rx_ferr, rx_valid}, 9'h001);
      @(posedge sys_clk);
   endtask
   task clk_word;
      clk_start <= 1'b1;
      @(posedge sys_clk);
      clk_start <= 1'b0;
   endtask
   // ---------------------------------------------------------------
   // scenarios
   // ---------------------------------------------------------------
   task t_reset;
      rdchk(ESPT_TXCTL_OFS, 8'hff, 8'h02);
      rdchk(5'h02, 8'hff, 8'h00);
      rdchk(ESPT_HOLD_OFS, 8'hff, 8'h00);
      wr_reg(ESPT_BAUDH_OFS, 8'h5a);
      rdchk(ESPT_BAUDH_OFS, 8'hff, 8'h5a);
      lvl(1'b0, 1'b0);
      $display("test reset done");
   endtask
   task t_async;
      wr_reg(ESPT_BAUDL_OFS, 8'h01);
      wr_reg(ESPT_RXCTL_OFS, 8'h80);
      wr_reg(ESPT_TXCTL_OFS, 8'h65);
      wr_reg(ESPT_HOLD_OFS, 8'ha5);
      rdchk(ESPT_TXCTL_OFS, 8'h02, 8'h00);
      wr_reg(ESPT_TXCTL_OFS, 8'h64);
      wr_reg(ESPT_HOLD_OFS, 8'h3c);
      rx_exp(9'h1a5);
      rx_exp(9'h03c);
      cyc(12);
      rdchk(ESPT_TXCTL_OFS, 8'h02, 8'h02);
      $display("test async done");
   endtask
   task t_pol;
      wr_reg(ESPT_RXCTL_OFS, 8'h81);
      pol <= 1'b1;
      nine <= 1'b0;
      wr_reg(ESPT_TXCTL_OFS, 8'h24);
      cyc(120);
      wr_reg(ESPT_HOLD_OFS, 8'h5a);
      rx_exp(9'h05a);
      cyc(260);
      chk({8'h00, lnk.tx_line}, 9'h000);
      $display("test polarity done");
   endtask
   task t_irq;
      pol <= 1'b0;
      wr_reg(ESPT_RXCTL_OFS, 8'h80);
      wr_reg(ESPT_TXCTL_OFS, 8'h00);
      wr_reg(ESPT_INTC_OFS, 8'h07);
      lvl(1'b0, 1'b0);
      wr_reg(ESPT_TXCTL_OFS, 8'h20);
      lvl(1'b1, 1'b1);
      rdchk(ESPT_INTC_OFS, 8'h08, 8'h08);
      rdchk(ESPT_EVST_OFS, 8'h01, 8'h01);
      wr_reg(ESPT_INTC_OFS, 8'h06);
      wr_reg(ESPT_EVST_OFS, 8'h01);
      wr_reg(ESPT_EVMSK_OFS, 8'h01);
      lvl(1'b0, 1'b0);
      wr_reg(ESPT_TXCTL_OFS, 8'h00);
      wr_reg(ESPT_TXCTL_OFS, 8'h20);
      lvl(1'b1, 1'b1);
      wr_reg(ESPT_EVST_OFS, 8'h01);
      lvl(1'b0, 1'b0);
      wr_reg(ESPT_EVMSK_OFS, 8'h00);
      wr_reg(ESPT_INTC_OFS, 8'h03);
      lvl(1'b0, 1'b1);
      $display("test interrupt done");
   endtask
   task t_sleep;
      sync_sel <= 1'b1;
      wr_reg(ESPT_TXCTL_OFS, 8'h00);
      wr_reg(ESPT_TXCTL_OFS, 8'h30);
      wr_reg(ESPT_HOLD_OFS, 8'h11);
      wr_reg(ESPT_HOLD_OFS, 8'h22);
      wr_reg(ESPT_HOLD_OFS, 8'h33);
      rdchk(ESPT_EVST_OFS, 8'h02, 8'h02);
      sleep_mode <= 1'b1;
      rdchk(ESPT_INTC_OFS, 8'h08, 8'h00);
      lvl(1'b0, 1'b0);
      clk_word();
      rx_exp(9'h011);
      cyc(12);
      lvl(1'b0, 1'b1);
      rdchk(ESPT_TXCTL_OFS, 8'h02, 8'h00);
      clk_word();
      rx_exp(9'h022);
      cyc(12);
      rdchk(ESPT_TXCTL_OFS, 8'h02, 8'h02);
      sleep_mode <= 1'b0;
      $display("test sleep done");
   endtask
   initial begin
      #400000;
      failures++;
      test_done();
   end
   initial begin
      rst_n = 1'b0;
      addr = 5'h00;
      wdata = 8'h00;
      wr = 1'b0;
      rd = 1'b0;
      sleep_mode = 1'b0;
      sync_sel = 1'b0;
      pol = 1'b0;
      nine = 1'b1;
      bit_cycles = 20'd8;
      clk_start = 1'b0;
      failures = 0;
      comparisons = 0;
      cyc(10);
      rst_n <= 1'b1;
      t_reset();
      t_async();
      t_pol();
      t_irq();
      t_sleep();
      test_done();
   end
endmodule

// File: test/espt_checker.sv
module espt_checker import espt_pkg::*; (
   input wire logic sys_clk, // clock
   input wire logic rst_n, // async reset, active low
   input wire logic tx_line, // serial data
   input wire logic sck, // shift clock
   input wire logic [4:0] addr, // register address
   input wire logic [7:0] wdata, // write data
   input wire logic wr, // write strobe
   input wire logic rd, // read strobe
   input wire logic [7:0] rdata, // read data
   input wire logic irq, // interrupt level
   input wire logic wake // wake level
);
   timeunit 1ns;
   timeprecision 1ps;
   logic sync_q, transmit_enable_q, pol_q, sck_q;
   logic [2:0] gate_q;
   logic [1:0] msk_q;
   logic [7:0] quiet_q;
   logic [3:0] rise_q;
   // ---------------------------------------------------------------
   // shadow of the control writes
   // ---------------------------------------------------------------
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         sync_q <= 1'b0;
         transmit_enable_q <= 1'b0;
         pol_q <= 1'b0;
         gate_q <= 3'h0;
         msk_q <= 2'h0;
      end else if (wr) begin
         if (addr == ESPT_TXCTL_OFS) begin
            sync_q <= wdata[ESPT_TX_SYNC_BIT];
            transmit_enable_q <= wdata[ESPT_TX_EN_BIT];
         end
         if (addr == ESPT_RXCTL_OFS) pol_q <= wdata[ESPT_RX_POL_BIT];
         if (addr == ESPT_INTC_OFS) gate_q <= wdata[2:0];
         if (addr == ESPT_EVMSK_OFS) msk_q <= wdata[1:0];
      end
   end
   // cycles since the last write and since the last shift clock rise
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         quiet_q <= 8'h00;
         rise_q <= 4'h0;
         sck_q <= 1'b0;
      end else begin
         quiet_q <= wr ? 8'h00 : (quiet_q == 8'hff ? quiet_q : quiet_q + 8'h01);
         rise_q <= (sck && !sck_q) ? 4'h0 : (rise_q == 4'hf ? rise_q : rise_q + 4'h1);
         sck_q <= sck;
      end
   end
   // ---------------------------------------------------------------
   // properties
   // ---------------------------------------------------------------
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!rst_n);
   sequence s_enable_write;
      wr && addr == ESPT_TXCTL_OFS && wdata[ESPT_TX_EN_BIT] && !transmit_enable_q;
   endsequence
   property p_enable_flag;
      s_enable_write ##0 gate_q == 3'h7 |=> ##[0:1] irq;
   endproperty
   a_enable_flag: assert property (p_enable_flag)
      else $error("enable did not raise the interrupt");
   property p_irq_gate;
      irq |-> wake;
   endproperty
   a_irq_gate: assert property (p_irq_gate)
      else $error("interrupt without wake level");
   property p_quiet_irq;
      !transmit_enable_q && msk_q == 2'h0 |-> !irq;
   endproperty
   a_quiet_irq: assert property (p_quiet_irq)
      else $error("interrupt with nothing enabled");
   property p_read_window;
      !$past(rd) |-> rdata == 8'h00;
   endproperty
   a_read_window: assert property (p_read_window)
      else $error("read data outside its cycle");
   property p_unmapped;
      rd && (addr[1:0] != 2'h0 || addr == ESPT_HOLD_OFS) |=> rdata == 8'h00;
   endproperty
   a_unmapped: assert property (p_unmapped)
      else $error("unreadable place returned data");
   property p_async_bit;
      transmit_enable_q && !sync_q && $changed(tx_line) |=> $stable(tx_line)[*7];
   endproperty
   a_async_bit: assert property (p_async_bit)
      else $error("async bit shorter than eight cycles");
   property p_sync_edge;
      sync_q && $changed(tx_line) |-> rise_q < 4'hc || quiet_q < 8'h08;
   endproperty
   a_sync_edge: assert property (p_sync_edge)
      else $error("sync line moved without a clock edge");
   property p_idle_level;
      transmit_enable_q && !sync_q && quiet_q == 8'hfa |-> tx_line == !pol_q;
   endproperty
   a_idle_level: assert property (p_idle_level)
      else $error("idle line level wrong");
endmodule
